// [design/tcs_top.sv]
// timer clock source selection, prescaler and event input edge detection
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
// Function
// RULE1 - prescale field picks 12, 4, 48 or external/8
// RULE2 - timer0 select bit: prescaled or system clock
// RULE3 - timer1 select bit: prescaled or system clock
// RULE4 - timer2 low byte: system or alternative clock
// RULE5 - timer2 high byte, split only: same choice
// RULE6 - timer3 low byte: system or alternative clock
// RULE7 - timer3 high byte, split only: same choice
// RULE8 - timer2/3 alternative: system/12 or external/8
// RULE9 - counter mode counts falling event edges
// RULE10 - events up to quarter system rate counted
// RULE11 - source holds each level two cycles
// RULE12 - timer3 runs from external clock in suspend
// RULE13 - counter select bit chooses event input
// RULE14 - event inputs synchronised before edge detect
module tcs_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_osc_clk,
    input wire logic event_input_zero,
    input wire logic event_input_one,
    output logic timer0_tick,
    output logic timer1_tick,
    output logic timer2_low_tick,
    output logic timer2_high_tick,
    output logic timer3_low_tick,
    output logic timer3_high_tick,
    output logic timer3_wake
);
    import tcs_pkg::*;

    // ***************************************************
    // registers over apb
    // ***************************************************
    logic [7:0] timer_clock_control_r;
    logic [7:0] cfg_r;
    logic [7:0] stat_w;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign addr_ok = (paddr == TCS_CLK_CTRL_ADDR) || (paddr == TCS_CFG_ADDR) ||
                     (paddr == TCS_STAT_ADDR);
    assign wr_en = clk_en && psel && penable && pwrite && !pready;
    assign rd_en = clk_en && psel && penable && !pwrite && !pready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_clock_control_r <= TCS_CLK_CTRL_RST;
            cfg_r <= TCS_CFG_RST;
        end else if (wr_en) begin
            if (paddr == TCS_CLK_CTRL_ADDR) begin
                timer_clock_control_r <= pwdata[7:0];
            end
            if (paddr == TCS_CFG_ADDR) begin
                cfg_r <= pwdata[7:0];
            end
        end
    end

    // one wait state: answer in the access cycle after it starts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (psel && penable && !pready) begin
                pready <= 1'b1;
                pslverr <= !addr_ok;
                prdata <= 32'h0000_0000;
                if (rd_en) begin
                    unique case (paddr)
                        TCS_CLK_CTRL_ADDR: prdata <= {24'h00_0000, timer_clock_control_r};
                        TCS_CFG_ADDR: prdata <= {24'h00_0000, cfg_r};
                        TCS_STAT_ADDR: prdata <= {24'h00_0000, stat_w};
                        default: prdata <= 32'h0000_0000;
                    endcase
                end
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    tcs_ps_t ps_sel;
    assign ps_sel = tcs_ps_t'(timer_clock_control_r[TCS_PS_LSB +: 2]);

    // ***************************************************
    // dividers of the system clock
    // ***************************************************
    logic [5:0] div12_cnt_r;
    logic [5:0] div4_cnt_r;
    logic [5:0] div48_cnt_r;
    logic div12_tick;
    logic div4_tick;
    logic div48_tick;

    assign div12_tick = clk_en && (div12_cnt_r == TCS_DIV12 - 6'd1);
    assign div4_tick = clk_en && (div4_cnt_r == TCS_DIV4 - 6'd1);
    assign div48_tick = clk_en && (div48_cnt_r == TCS_DIV48 - 6'd1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div12_cnt_r <= 6'd0;
            div4_cnt_r <= 6'd0;
            div48_cnt_r <= 6'd0;
        end else if (clk_en) begin
            div12_cnt_r <= div12_tick ? 6'd0 : div12_cnt_r + 6'd1; // see RULE1
            div4_cnt_r <= div4_tick ? 6'd0 : div4_cnt_r + 6'd1; // see RULE1
            div48_cnt_r <= div48_tick ? 6'd0 : div48_cnt_r + 6'd1; // see RULE1
        end
    end

    // ***************************************************
    // external oscillator, synchronised and divided by 8
    // ***************************************************
    // the oscillator must run below half the system rate to be seen;
    // the trade is one clock domain instead of a proper crossing
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic [5:0] ext_cnt_r;
    logic ext_rise;
    logic ext8_tick;

    assign ext_rise = ext_s2_r && !ext_s3_r;
    assign ext8_tick = clk_en && ext_rise && (ext_cnt_r == TCS_DIV8 - 6'd1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            ext_cnt_r <= 6'd0;
        end else if (clk_en) begin
            ext_s1_r <= ext_osc_clk;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (ext_rise) begin
                ext_cnt_r <= ext8_tick ? 6'd0 : ext_cnt_r + 6'd1; // see RULE1
            end
        end
    end

    // ***************************************************
    // event inputs: synchroniser and falling edge detect
    // ***************************************************
    logic [1:0] ev_s1_r;
    logic [1:0] ev_s2_r;
    logic [1:0] ev_s3_r;
    logic [1:0] ev_fall;

    // a level must hold two system cycles or the edge may be missed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_s1_r <= 2'b11;
            ev_s2_r <= 2'b11;
            ev_s3_r <= 2'b11;
        end else if (clk_en) begin
            ev_s1_r <= {event_input_one, event_input_zero}; // see RULE14
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end
    assign ev_fall = ev_s3_r & ~ev_s2_r; // see RULE14, RULE10, RULE11

    // ***************************************************
    // source selection
    // ***************************************************
    logic ps_tick;
    logic t2_alt_tick;
    logic t3_alt_tick;
    logic t0_nxt;
    logic t1_nxt;
    logic t2l_nxt;
    logic t2h_nxt;
    logic t3l_nxt;
    logic t3h_nxt;
    logic suspend;

    assign suspend = cfg_r[TCS_SUSPEND_BIT];

    always_comb begin
        unique case (ps_sel)
            TCS_PS_SYS12: ps_tick = div12_tick; // see RULE1
            TCS_PS_SYS4: ps_tick = div4_tick;
            TCS_PS_SYS48: ps_tick = div48_tick;
            TCS_PS_EXT8: ps_tick = ext8_tick;
        endcase
    end

    assign t2_alt_tick = cfg_r[TCS_T2_ALT_BIT] ? ext8_tick : div12_tick; // see RULE8
    assign t3_alt_tick = cfg_r[TCS_T3_ALT_BIT] ? ext8_tick : div12_tick; // see RULE8

    always_comb begin
        if (cfg_r[TCS_T0_CNT_BIT]) begin
            t0_nxt = clk_en && ev_fall[0]; // see RULE9, RULE13
        end else begin
            t0_nxt = timer_clock_control_r[TCS_T0_SEL_BIT] ? clk_en : ps_tick; // see RULE2
        end
        if (cfg_r[TCS_T1_CNT_BIT]) begin
            t1_nxt = clk_en && ev_fall[1]; // see RULE9
        end else begin
            t1_nxt = timer_clock_control_r[TCS_T1_SEL_BIT] ? clk_en : ps_tick; // see RULE3
        end
        t2l_nxt = timer_clock_control_r[TCS_T2L_SEL_BIT] ? clk_en : t2_alt_tick; // see RULE4
        t2h_nxt = cfg_r[TCS_T2_SPLIT_BIT] &&
                  (timer_clock_control_r[TCS_T2H_SEL_BIT] ? clk_en : t2_alt_tick); // see RULE5
        // in suspend only the external oscillator keeps timer3 going
        if (suspend) begin
            t3l_nxt = ext8_tick; // see RULE12
            t3h_nxt = cfg_r[TCS_T3_SPLIT_BIT] && ext8_tick;
        end else begin
            t3l_nxt = timer_clock_control_r[TCS_T3L_SEL_BIT] ? clk_en : t3_alt_tick; // see RULE6
            t3h_nxt = cfg_r[TCS_T3_SPLIT_BIT] &&
                      (timer_clock_control_r[TCS_T3H_SEL_BIT] ? clk_en : t3_alt_tick); // see RULE7
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer0_tick <= 1'b0;
            timer1_tick <= 1'b0;
            timer2_low_tick <= 1'b0;
            timer2_high_tick <= 1'b0;
            timer3_low_tick <= 1'b0;
            timer3_high_tick <= 1'b0;
            timer3_wake <= 1'b0;
        end else begin
            timer0_tick <= t0_nxt;
            timer1_tick <= t1_nxt;
            timer2_low_tick <= t2l_nxt;
            timer2_high_tick <= t2h_nxt;
            timer3_low_tick <= t3l_nxt;
            timer3_high_tick <= t3h_nxt;
            timer3_wake <= suspend && t3l_nxt; // see RULE12
        end
    end

    assign stat_w = {1'b0, timer3_wake, ext_s2_r, ev_s2_r, timer3_low_tick,
                     timer2_low_tick, ps_tick};

    // ***************************************************
    // checks
    // ***************************************************
    a_t0_sysclk: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE2
        clk_en && !cfg_r[TCS_T0_CNT_BIT] && timer_clock_control_r[TCS_T0_SEL_BIT]
        |=> timer0_tick) else $error("timer0 system clock tick missing");
    a_t1_sysclk: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE3
        clk_en && !cfg_r[TCS_T1_CNT_BIT] && timer_clock_control_r[TCS_T1_SEL_BIT]
        |=> timer1_tick) else $error("timer1 system clock tick missing");
    a_div12_period: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE1
        div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3])
        else $error("divide by 12 too fast");
    a_div4_spacing: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE1
        div4_tick |=> !div4_tick [*3]) else $error("divide by 4 too fast");
    a_ev0_count: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE9
        clk_en && cfg_r[TCS_T0_CNT_BIT] && ev_fall[0] |=> timer0_tick)
        else $error("timer0 event edge not counted");
    a_ev0_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE13
        cfg_r[TCS_T0_CNT_BIT] && !ev_fall[0] |=> !timer0_tick)
        else $error("timer0 counted without an event");
    a_t2h_split: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE5
        !cfg_r[TCS_T2_SPLIT_BIT] |=> !timer2_high_tick)
        else $error("timer2 high byte ticked outside split mode");
    a_t2l_sys: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE4
        clk_en && timer_clock_control_r[TCS_T2L_SEL_BIT] |=> timer2_low_tick)
        else $error("timer2 low byte system tick missing");
    a_t3_suspend: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE12
        suspend && !ext8_tick |=> !timer3_low_tick && !timer3_wake)
        else $error("timer3 ticked in suspend without oscillator");
endmodule

// [dv/tb_top.sv]
// self-checking bench for the timer clock source select block
`timescale 1ns/10ps
module tb_top;
    import tcs_pkg::*;
    localparam int N = 480;
    logic core_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, ck, cf;
    logic ext_osc_clk, event_input_zero, event_input_one;
    wire [6:0] tick;
    logic [1:0] mask;
    int cnt[7];
    int failures, cmp_count, k, hold;
    int dv[3] = '{12, 4, 48};

    tcs_top i_tcs_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_osc_clk(ext_osc_clk),
        .event_input_zero(event_input_zero), .event_input_one(event_input_one),
        .timer0_tick(tick[0]), .timer1_tick(tick[1]), .timer2_low_tick(tick[2]),
        .timer2_high_tick(tick[3]), .timer3_low_tick(tick[4]), .timer3_high_tick(tick[5]),
        .timer3_wake(tick[6]));
    tcs_ext_model i_tcs_ext_model (.core_clk(core_clk), .ext_osc_clk(ext_osc_clk),
        .event_input_zero(event_input_zero), .event_input_one(event_input_one));

    // ******************************
    // helpers
    // ******************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // tick counts may be one off because the window start is not aligned
    function automatic logic [31:0] near(input int seen, input int exp);
        return ((seen - exp) <= 1 && (exp - seen) <= 1) ? 32'(exp) : 32'(seen);
    endfunction
    task automatic cnt_chk(input int i, input int e);
        check(near(cnt[i], e), 32'(e));
    endtask
    function automatic int ext_exp();
        return N * 50 / 1040;
    endfunction
    function automatic int t23_exp(input logic sel, input logic alt);
        if (sel) begin
            return N;
        end
        return alt ? ext_exp() : N / 12;
    endfunction
    // pready is sampled at the rising edge; data taken and request released at that edge
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int g;
        g = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            g++;
        end while (pready !== 1'b1 && g < 20);
        if (pready !== 1'b1) begin
            failures++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic measure(input int n);
        cnt = '{default: 0};
        repeat (n) begin
            @(posedge core_clk);
            #1;
            for (int i = 0; i < 7; i++) cnt[i] += int'(tick[i] === 1'b1);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ******************************
    // sequence
    // ******************************
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #3000000;
        failures++;
        print_verdict();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'b1;
        seed = 32'd29519;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, TCS_CLK_CTRL_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, TCS_CFG_ADDR, 32'h0);
        check(rd, 32'h0);
        ck = rnd();
        apb(1'b1, TCS_CLK_CTRL_ADDR, ck);
        apb(1'b1, 10'h040, rnd());
        check({31'h0, err}, 32'h1);
        apb(1'b0, TCS_CLK_CTRL_ADDR, 32'h0);
        check(rd, ck & 32'hff);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, TCS_CLK_CTRL_ADDR, 32'(p));
            measure(N);
            k = (p == 3) ? ext_exp() : N / dv[p];
            cnt_chk(0, k);
            cnt_chk(1, k);
        end
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, TCS_CLK_CTRL_ADDR, 32'h2 | (32'h4 << s));
            measure(N);
            cnt_chk(s, N);
            cnt_chk(1 - s, 10);
        end
        for (int i = 0; i < 6; i++) begin
            ck = (i < 2) ? 32'h0 : rnd() & 32'hf0;
            cf = (i < 2) ? 32'h30 | (32'hc * i) : (rnd() & 32'hc) | 32'h30;
            apb(1'b1, TCS_CLK_CTRL_ADDR, ck);
            apb(1'b1, TCS_CFG_ADDR, cf);
            measure(N);
            cnt_chk(2, t23_exp(ck[4], cf[2]));
            cnt_chk(3, t23_exp(ck[5], cf[2]));
            cnt_chk(4, t23_exp(ck[6], cf[3]));
            cnt_chk(5, t23_exp(ck[7], cf[3]));
        end
        apb(1'b1, TCS_CFG_ADDR, 32'h70);
        measure(N);
        cnt_chk(4, ext_exp());
        cnt_chk(6, ext_exp());
        // select bits set on purpose: counter mode must override them
        apb(1'b1, TCS_CLK_CTRL_ADDR, 32'h0c);
        apb(1'b1, TCS_CFG_ADDR, 32'h03);
        for (int r = 0; r < 3; r++) begin
            k = 1 + int'(rnd() % 6);
            hold = (r == 0) ? 2 : 2 + int'(rnd() % 3);
            mask = (r == 0) ? 2'b11 : 2'(1 + rnd() % 3);
            fork
                measure(64);
                repeat (k) i_tcs_ext_model.pulse(mask, hold);
            join
            check(32'(cnt[0]), mask[0] ? 32'(k) : 32'h0);
            check(32'(cnt[1]), mask[1] ? 32'(k) : 32'h0);
        end
        apb(1'b1, TCS_CFG_ADDR, 32'h0);
        // counter mode off and split off: high bytes must stay silent
        measure(N);
        cnt_chk(0, N);
        check(32'(cnt[3]), 32'h0);
        check(32'(cnt[5]), 32'h0);
        @(posedge core_clk);
        clk_en <= 1'b0;
        @(posedge core_clk);
        measure(20);
        check(32'(cnt[0]), 32'h0);
        clk_en <= 1'b1;
        print_verdict();
    end
endmodule

// [dv/tcs_ext_model.sv]
// model of the external oscillator and the two event pins
`timescale 1ns/10ps
module tcs_ext_model (
    input wire logic core_clk,
    output logic ext_osc_clk,
    output logic event_input_zero,
    output logic event_input_one
);
    // ******************************
    // oscillator and event pins
    // ******************************
    // free running, kept well below half the system clock rate
    initial begin
        ext_osc_clk = 1'b0;
        forever #65 ext_osc_clk = ~ext_osc_clk;
    end
    // pins idle high as with a pull-up
    initial begin
        event_input_zero = 1'b1;
        event_input_one = 1'b1;
    end
    // one falling edge on every pin in mask, each level kept hold cycles
    task automatic pulse(input logic [1:0] mask, input int hold);
        @(posedge core_clk);
        event_input_zero <= ~mask[0];
        event_input_one <= ~mask[1];
        repeat (hold) @(posedge core_clk);
        event_input_zero <= 1'b1;
        event_input_one <= 1'b1;
        repeat (hold - 1) @(posedge core_clk);
    endtask
endmodule

// [inc/tcs_pkg.sv]
// constants for the timer clock source select block
package tcs_pkg;
    // register indices; one word each, so the apb byte address is four times the index
    localparam logic [7:0] TCS_CLK_CTRL_IDX = 8'h8e;
    localparam logic [7:0] TCS_CFG_IDX = 8'h90;
    localparam logic [7:0] TCS_STAT_IDX = 8'h94;
    localparam logic [9:0] TCS_CLK_CTRL_ADDR = {TCS_CLK_CTRL_IDX, 2'b00};
    localparam logic [9:0] TCS_CFG_ADDR = {TCS_CFG_IDX, 2'b00};
    localparam logic [9:0] TCS_STAT_ADDR = {TCS_STAT_IDX, 2'b00};
    localparam logic [7:0] TCS_CLK_CTRL_RST = 8'h00;
    localparam logic [7:0] TCS_CFG_RST = 8'h00;
    // clock control fields
    localparam int TCS_PS_LSB = 0;
    localparam int TCS_T0_SEL_BIT = 2;
    localparam int TCS_T1_SEL_BIT = 3;
    localparam int TCS_T2L_SEL_BIT = 4;
    localparam int TCS_T2H_SEL_BIT = 5;
    localparam int TCS_T3L_SEL_BIT = 6;
    localparam int TCS_T3H_SEL_BIT = 7;
    // configuration fields
    localparam int TCS_T0_CNT_BIT = 0;
    localparam int TCS_T1_CNT_BIT = 1;
    localparam int TCS_T2_ALT_BIT = 2;
    localparam int TCS_T3_ALT_BIT = 3;
    localparam int TCS_T2_SPLIT_BIT = 4;
    localparam int TCS_T3_SPLIT_BIT = 5;
    localparam int TCS_SUSPEND_BIT = 6;
    // divide ratios
    localparam logic [5:0] TCS_DIV12 = 6'd12;
    localparam logic [5:0] TCS_DIV4 = 6'd4;
    localparam logic [5:0] TCS_DIV48 = 6'd48;
    localparam logic [5:0] TCS_DIV8 = 6'd8;
    typedef enum logic [1:0] {
        TCS_PS_SYS12 = 2'b00,
        TCS_PS_SYS4 = 2'b01,
        TCS_PS_SYS48 = 2'b10,
        TCS_PS_EXT8 = 2'b11
    } tcs_ps_t;
endpackage
